// File: design/sync_status_control.sv
// Purpose: Register bank for reference-pulse phase alignment control and status
// Assumes: Reference strobe is one cycle wide and synchronous to sys_clk
// Notes: Adjustment is a one-cycle pulse with the error for the clock rotator
//
// Contract
// - Last error is nine bits: low byte at 0x038, top bit at 0x039 bit 0.
// - Last error is sampled phase minus target, in converter clocks.
// - Last error is sticky; it changes only on a clock adjustment or a control bit 4 clear.
// - Writing 1 to control bit 4 clears last error and its under/over flags.
// - High error bit 7 reads 1 when error lies below the window.
// - High error bit 6 reads 1 when error lies above the window.
// - Control bit 7 enables alignment logic; resets to 0, disabled.
// - Setting control bit 6 arms one alignment on a later reference pulse.
// - Writing 1 to control bit 5 clears rotation and window trip flags.
// - Three-bit window code sets tolerance; zero allows none, up to seven.
// - Mode selects one-shot, continuous, monitor, or one-shot then monitor.
`timescale 1ns/1ps
module sync_status_control
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe,
    input wire logic sysref_strobe,
    input wire logic [sync_regs_pkg::ERR_W-1:0] sampled_phase,
    input wire logic [sync_regs_pkg::ERR_W-1:0] target_phase,
    output logic clock_adjust,
    output logic [sync_regs_pkg::ERR_W-1:0] adjust_error,
    output logic reference_rotation_flag,
    output logic window_trip_flag
);
    sync_regs_pkg::reg_req_t req;
    sync_regs_pkg::phase_result_t result;
    logic [7:0] reg_rdata;

    // Stored state
    logic alignment_logic_on;
    logic [sync_regs_pkg::WINDOW_W-1:0] phase_tolerance_window;
    logic [sync_regs_pkg::MODE_W-1:0] alignment_mode_select;
    logic armed;
    logic shot_done;
    logic [sync_regs_pkg::ERR_W-1:0] last_phase_error;
    logic last_error_below_window;
    logic last_error_above_window;

    spi_reg_port u_port
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .spi_sclk(spi_sclk),
        .spi_csn(spi_csn),
        .spi_sdio_in(spi_sdio_in),
        .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe(spi_sdio_oe),
        .req(req),
        .reg_rdata(reg_rdata)
    );

    phase_window_compare #(
        .WIN_W(sync_regs_pkg::WINDOW_W)
    ) u_compare
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .sysref_strobe(sysref_strobe),
        .sampled_phase(sampled_phase),
        .target_phase(target_phase),
        .window_code(phase_tolerance_window),
        .result(result)
    );

    // Address decode
    wire sel_window = req.addr == sync_regs_pkg::ADDR_WINDOW;
    wire sel_err_low = req.addr == sync_regs_pkg::ADDR_ERR_LOW;
    wire sel_err_high = req.addr == sync_regs_pkg::ADDR_ERR_HIGH;
    wire sel_control = req.addr == sync_regs_pkg::ADDR_CONTROL;
    wire sel_mode = req.addr == sync_regs_pkg::ADDR_MODE;
    wire sel_status = req.addr == sync_regs_pkg::ADDR_STATUS;

    wire wr_window = req.wr & sel_window;
    wire wr_control = req.wr & sel_control;
    wire wr_mode = req.wr & sel_mode;

    // Write strobes, effective only in the write cycle
    wire one_shot_arm = wr_control & req.wdata[sync_regs_pkg::BIT_ARM];
    wire sticky_flag_clear = wr_control & req.wdata[sync_regs_pkg::BIT_CLR_STICKY];
    wire last_error_clear = wr_control & req.wdata[sync_regs_pkg::BIT_CLR_LAST];

    // Mode decode
    wire mode_one_shot = alignment_mode_select == sync_regs_pkg::MODE_ONE_SHOT;
    wire mode_continuous = alignment_mode_select == sync_regs_pkg::MODE_CONTINUOUS;
    wire mode_monitor = alignment_mode_select == sync_regs_pkg::MODE_MONITOR;
    wire mode_shot_mon = alignment_mode_select == sync_regs_pkg::MODE_SHOT_MON_A
        || alignment_mode_select == sync_regs_pkg::MODE_SHOT_MON_B;
    wire mode_uses_arm = mode_one_shot | mode_shot_mon;

    // Reference pulse handling
    wire pulse_seen = result.valid & alignment_logic_on;
    wire shot_taken = pulse_seen & mode_uses_arm & armed;
    wire align_now = shot_taken | (pulse_seen & mode_continuous);
    wire monitoring = mode_monitor | (mode_shot_mon & shot_done);
    wire adjust_now = align_now & result.outside;
    wire trip_now = pulse_seen & result.outside & (align_now | monitoring);

    // Read data
    wire [7:0] rd_window = {{(8-sync_regs_pkg::WINDOW_W){1'b0}}, phase_tolerance_window};
    wire [7:0] rd_err_low = last_phase_error[7:0];
    wire [7:0] rd_err_high = {last_error_below_window, last_error_above_window, 5'h00,
        last_phase_error[sync_regs_pkg::ERR_W-1]};
    wire [7:0] rd_control = {alignment_logic_on, 7'h00};
    wire [7:0] rd_mode = {{(8-sync_regs_pkg::MODE_W){1'b0}}, alignment_mode_select};
    wire [7:0] rd_status = {6'h00, reference_rotation_flag, window_trip_flag};

    assign reg_rdata = sel_window ? rd_window
        : sel_err_low ? rd_err_low
        : sel_err_high ? rd_err_high
        : sel_control ? rd_control
        : sel_mode ? rd_mode
        : sel_status ? rd_status
        : 8'h00;

    // Configuration registers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            alignment_logic_on <= sync_regs_pkg::RST_ON;
            phase_tolerance_window <= sync_regs_pkg::RST_WINDOW;
            alignment_mode_select <= sync_regs_pkg::RST_MODE;
        end
        else
        begin
            if (wr_control)
                alignment_logic_on <= req.wdata[sync_regs_pkg::BIT_ON];
            if (wr_window)
                phase_tolerance_window <= req.wdata[sync_regs_pkg::WINDOW_W-1:0];
            if (wr_mode)
                alignment_mode_select <= req.wdata[sync_regs_pkg::MODE_W-1:0];
        end
    end

    // Arming; a new arm wins over the pulse that consumes the old one
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            armed <= 1'b0;
            shot_done <= 1'b0;
        end
        else
        begin
            if (one_shot_arm)
                armed <= 1'b1;
            else if (shot_taken)
                armed <= 1'b0;
            if (one_shot_arm)
                shot_done <= 1'b0;
            else if (shot_taken)
                shot_done <= 1'b1;
        end
    end

    // Sticky last error record; a new adjustment wins over a clear
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            last_phase_error <= sync_regs_pkg::RST_ERR;
            last_error_below_window <= 1'b0;
            last_error_above_window <= 1'b0;
        end
        else if (adjust_now)
        begin
            last_phase_error <= result.error;
            last_error_below_window <= result.under;
            last_error_above_window <= result.over;
        end
        else if (last_error_clear)
        begin
            last_phase_error <= sync_regs_pkg::RST_ERR;
            last_error_below_window <= 1'b0;
            last_error_above_window <= 1'b0;
        end
    end

    // Sticky status flags; set wins over clear
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reference_rotation_flag <= 1'b0;
            window_trip_flag <= 1'b0;
        end
        else
        begin
            if (adjust_now)
                reference_rotation_flag <= 1'b1;
            else if (sticky_flag_clear)
                reference_rotation_flag <= 1'b0;
            if (trip_now)
                window_trip_flag <= 1'b1;
            else if (sticky_flag_clear)
                window_trip_flag <= 1'b0;
        end
    end

    // Adjustment request to the clock rotator
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clock_adjust <= 1'b0;
            adjust_error <= sync_regs_pkg::RST_ERR;
        end
        else
        begin
            clock_adjust <= adjust_now;
            if (adjust_now)
                adjust_error <= result.error;
        end
    end
endmodule

// File: common/sync_regs_pkg.sv
// Purpose: Shared constants and carriers for the reference alignment register bank
// Assumes: Serial port frames of 16 instruction bits and 8 data bits
// Notes: Phase values are 9-bit two's complement counts of converter clocks
package sync_regs_pkg;

    // Register offsets
    localparam logic [14:0] ADDR_WINDOW = 15'h034;
    localparam logic [14:0] ADDR_ERR_LOW = 15'h038;
    localparam logic [14:0] ADDR_ERR_HIGH = 15'h039;
    localparam logic [14:0] ADDR_CONTROL = 15'h03a;
    localparam logic [14:0] ADDR_MODE = 15'h03b;
    localparam logic [14:0] ADDR_STATUS = 15'h03c;

    // Field positions
    localparam int BIT_UNDER = 7;
    localparam int BIT_OVER = 6;
    localparam int BIT_ERR_TOP = 0;
    localparam int BIT_ON = 7;
    localparam int BIT_ARM = 6;
    localparam int BIT_CLR_STICKY = 5;
    localparam int BIT_CLR_LAST = 4;
    localparam int BIT_ROTATION = 1;
    localparam int BIT_TRIP = 0;

    // Widths
    localparam int ERR_W = 9;
    localparam int WINDOW_W = 3;
    localparam int MODE_W = 4;

    // Values after reset
    localparam logic RST_ON = 1'h0;
    localparam logic [WINDOW_W-1:0] RST_WINDOW = 3'h0;
    localparam logic [MODE_W-1:0] RST_MODE = 4'h0;
    localparam logic [ERR_W-1:0] RST_ERR = 9'h000;

    // Mode codes
    localparam logic [MODE_W-1:0] MODE_ONE_SHOT = 4'h1;
    localparam logic [MODE_W-1:0] MODE_CONTINUOUS = 4'h2;
    localparam logic [MODE_W-1:0] MODE_MONITOR = 4'h8;
    localparam logic [MODE_W-1:0] MODE_SHOT_MON_A = 4'h9;
    localparam logic [MODE_W-1:0] MODE_SHOT_MON_B = 4'ha;

    // Serial frame counts
    localparam logic [4:0] SPI_INSTR_LAST = 5'h0f;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
    localparam int SPI_RW_BIT = 15;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [14:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed
    {
        logic valid;
        logic outside;
        logic under;
        logic over;
        logic [ERR_W-1:0] error;
    } phase_result_t;

endpackage

// File: design/spi_reg_port.sv
// Purpose: Serial configuration port turned into register read and write pulses
// Assumes: Serial clock high and low phases each last at least two system clocks
// Notes: Mode 0, MSB first, one data byte per frame, instruction bit 15 high for read
`timescale 1ns/1ps
module spi_reg_port
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe,
    output sync_regs_pkg::reg_req_t req,
    input wire logic [7:0] reg_rdata
);
    typedef enum logic [1:0] {IDLE, INSTR, WRITE_DATA, READ_DATA} spi_state_t;

    spi_state_t state;
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [7:0] shift_out;

    wire rise = spi_sclk & ~sclk_q & ~spi_csn;
    wire fall = ~spi_sclk & sclk_q & ~spi_csn;
    wire [15:0] next_shift = {shift_in[14:0], spi_sdio_in};
    wire instr_done = rise && bit_cnt == sync_regs_pkg::SPI_INSTR_LAST;
    wire frame_done = rise && bit_cnt == sync_regs_pkg::SPI_FRAME_LAST;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= IDLE;
            sclk_q <= 1'b0;
            bit_cnt <= 5'h00;
            shift_in <= 16'h0000;
            shift_out <= 8'h00;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe <= 1'b0;
            req <= '0;
        end
        else
        begin
            sclk_q <= spi_sclk;
            req.wr <= 1'b0;
            req.rd <= 1'b0;
            if (spi_csn)
            begin
                state <= IDLE;
                bit_cnt <= 5'h00;
                spi_sdio_oe <= 1'b0;
            end
            else
            begin
                if (rise && state != IDLE)
                begin
                    shift_in <= next_shift;
                    bit_cnt <= bit_cnt + 5'h01;
                end
                if (req.rd)
                    shift_out <= reg_rdata;
                case (state)
                    IDLE:
                    begin
                        if (rise)
                        begin
                            state <= INSTR;
                            shift_in <= next_shift;
                            bit_cnt <= 5'h01;
                        end
                    end
                    INSTR:
                    begin
                        if (instr_done)
                        begin
                            req.addr <= next_shift[14:0];
                            req.rd <= next_shift[sync_regs_pkg::SPI_RW_BIT];
                            state <= next_shift[sync_regs_pkg::SPI_RW_BIT] ? READ_DATA : WRITE_DATA;
                        end
                    end
                    WRITE_DATA:
                    begin
                        if (frame_done)
                        begin
                            req.wdata <= next_shift[7:0];
                            req.wr <= 1'b1;
                            state <= IDLE;
                        end
                    end
                    READ_DATA:
                    begin
                        if (fall)
                        begin
                            spi_sdio_out <= shift_out[7];
                            shift_out <= {shift_out[6:0], 1'b0};
                            spi_sdio_oe <= 1'b1;
                        end
                    end
                    default:
                        state <= IDLE;
                endcase
            end
        end
    end
endmodule

// File: design/phase_window_compare.sv
// Purpose: Measures reference phase error and checks it against the tolerance window
// Assumes: Phase inputs are valid in the cycle of the reference strobe
// Notes: Result appears one cycle after the strobe
`timescale 1ns/1ps
module phase_window_compare
#(
    parameter int WIN_W = sync_regs_pkg::WINDOW_W
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sysref_strobe,
    input wire logic [sync_regs_pkg::ERR_W-1:0] sampled_phase,
    input wire logic [sync_regs_pkg::ERR_W-1:0] target_phase,
    input wire logic [WIN_W-1:0] window_code,
    output sync_regs_pkg::phase_result_t result
);
    if (WIN_W < 1 || WIN_W >= sync_regs_pkg::ERR_W)
    begin : g_bad_width
        $error("Window width must be below the error width");
    end

    // Signed difference, one bit wider to compare safely
    wire [sync_regs_pkg::ERR_W-1:0] diff = sampled_phase - target_phase;
    wire signed [sync_regs_pkg::ERR_W:0] err_ext = $signed({diff[sync_regs_pkg::ERR_W-1], diff});
    wire signed [sync_regs_pkg::ERR_W:0] tol = $signed({{(sync_regs_pkg::ERR_W+1-WIN_W){1'b0}}, window_code});
    wire below = err_ext < -tol;
    wire above = err_ext > tol;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            result <= '0;
        else
        begin
            result.valid <= sysref_strobe;
            if (sysref_strobe)
            begin
                result.error <= diff;
                result.under <= below;
                result.over <= above;
                result.outside <= below | above;
            end
        end
    end
endmodule

// File: dv/sync_status_control_properties.sv
// Purpose: Port-level checks for the alignment register bank
// Assumes: Single sys_clk domain, resetn active low
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
module sync_status_control_properties
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic spi_csn,
    input wire logic spi_sdio_oe,
    input wire logic sysref_strobe,
    input wire logic [8:0] sampled_phase,
    input wire logic [8:0] target_phase,
    input wire logic clock_adjust,
    input wire logic [8:0] adjust_error,
    input wire logic reference_rotation_flag,
    input wire logic window_trip_flag
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_csn_high;
        $rose(spi_csn) ##0 spi_csn [*3];
    endsequence

    property p_adjust_cause;
        clock_adjust |-> $past(sysref_strobe, 2);
    endproperty
    property p_adjust_error;
        clock_adjust |-> adjust_error == $past(sampled_phase, 2) - $past(target_phase, 2);
    endproperty
    property p_error_sticky;
        $changed(adjust_error) |-> clock_adjust;
    endproperty
    property p_rotation_set;
        $rose(reference_rotation_flag) |-> clock_adjust;
    endproperty
    property p_adjust_flags;
        clock_adjust |-> reference_rotation_flag && window_trip_flag;
    endproperty
    property p_trip_cause;
        $rose(window_trip_flag) |-> $past(sysref_strobe, 2);
    endproperty
    property p_flag_clear;
        $fell(reference_rotation_flag) || $fell(window_trip_flag) |-> !$past(spi_csn);
    endproperty
    property p_oe_in_frame;
        $rose(spi_sdio_oe) |-> !spi_csn;
    endproperty
    property p_oe_drop;
        s_csn_high |-> !spi_sdio_oe;
    endproperty

    a_adjust_cause: assert property (p_adjust_cause) else $error("adjust without strobe");
    a_adjust_error: assert property (p_adjust_error) else $error("adjust error value");
    a_error_sticky: assert property (p_error_sticky) else $error("error moved");
    a_rotation_set: assert property (p_rotation_set) else $error("rotation flag cause");
    a_adjust_flags: assert property (p_adjust_flags) else $error("flags on adjust");
    a_trip_cause: assert property (p_trip_cause) else $error("trip flag cause");
    a_flag_clear: assert property (p_flag_clear) else $error("flag fell outside write");
    a_oe_in_frame: assert property (p_oe_in_frame) else $error("drive outside frame");
    a_oe_drop: assert property (p_oe_drop) else $error("drive after frame");
endmodule

// File: dv/spi_host_model.sv
// Purpose: Serial port host and reference pulse source
// Assumes: Tasks entered just after a sys_clk rising edge
// Notes: Mode 0, sclk idle low, three sys_clk per half period
`timescale 1ns/1ps
module spi_host_model
(
    input wire logic sys_clk,
    input wire logic spi_sdio_out,
    input wire logic spi_sdio_oe,
    output logic spi_sclk,
    output logic spi_csn,
    output logic spi_sdio_in,
    output logic sysref_strobe,
    output logic [8:0] sampled_phase,
    output logic [8:0] target_phase
);
    logic host_bit;
    logic idle_bit;

    // Wire level from both drivers; idle line toggles
    assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : (spi_csn ? idle_bit : host_bit);

    initial
    begin
        spi_sclk = 1'b0;
        spi_csn = 1'b1;
        host_bit = 1'b0;
        idle_bit = 1'b0;
        sysref_strobe = 1'b0;
        sampled_phase = 9'h000;
        target_phase = 9'h000;
    end

    always @(posedge sys_clk)
        idle_bit <= ~idle_bit;

    task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [23:0] sh;
        sh = {rd, a, wd};
        q = 8'h00;
        spi_csn <= 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            host_bit <= (rd && i > 15) ? ~host_bit : sh[23-i];
            repeat (3) @(posedge sys_clk);
            if (i > 15)
                q[23-i] = spi_sdio_in;
            spi_sclk <= 1'b1;
            repeat (3) @(posedge sys_clk);
            spi_sclk <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
        spi_csn <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic pulse(input logic [8:0] s, input logic [8:0] t);
        sysref_strobe <= 1'b1;
        sampled_phase <= s;
        target_phase <= t;
        @(posedge sys_clk);
        sysref_strobe <= 1'b0;
        sampled_phase <= ~s;
        target_phase <= 9'h0aa ^ t;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// File: dv/sync_status_control_test.sv
// Purpose: Register-level regression of the alignment bank
// Assumes: Host model drives all serial and reference inputs
// Notes: Adjust pulses are counted at the ports
`timescale 1ns/1ps
module sync_status_control_test;
    logic sys_clk, resetn, spi_sclk, spi_csn, spi_sdio_in, spi_sdio_out, spi_sdio_oe;
    logic sysref_strobe, clock_adjust, reference_rotation_flag, window_trip_flag;
    logic [8:0] sampled_phase, target_phase, adjust_error;
    logic [7:0] q;
    int num_errors, n_compared, n_adjust, cycles;

    spi_host_model u_spi_host_model (.sys_clk(sys_clk), .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe(spi_sdio_oe), .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_sdio_in(spi_sdio_in),
        .sysref_strobe(sysref_strobe), .sampled_phase(sampled_phase), .target_phase(target_phase));

    sync_status_control u_sync_status_control (.sys_clk(sys_clk), .resetn(resetn), .spi_sclk(spi_sclk),
        .spi_csn(spi_csn), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
        .sysref_strobe(sysref_strobe), .sampled_phase(sampled_phase), .target_phase(target_phase),
        .clock_adjust(clock_adjust), .adjust_error(adjust_error),
        .reference_rotation_flag(reference_rotation_flag), .window_trip_flag(window_trip_flag));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic print_verdict;
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t read %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int exp);
        n_compared++;
        if (n_adjust != exp)
        begin
            num_errors++;
            $display("[FAIL] %0t adjusts %0d want %0d", $time, n_adjust, exp);
        end
    endtask

    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        u_spi_host_model.frame(1'b1, a, 8'h00, q);
        chk(q, e);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        u_spi_host_model.frame(1'b0, a, d, q);
    endtask

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (clock_adjust === 1'b1)
            n_adjust <= n_adjust + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    initial
    begin
        resetn = 1'b0;
        num_errors = 0;
        n_compared = 0;
        n_adjust = 0;
        cycles = 0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(sync_regs_pkg::ADDR_ERR_LOW, 8'h00);
        rd(sync_regs_pkg::ADDR_ERR_HIGH, 8'h00);
        rd(sync_regs_pkg::ADDR_CONTROL, 8'h00);
        rd(15'h100, 8'h00);
        wr(sync_regs_pkg::ADDR_CONTROL, 8'hb0);
        rd(sync_regs_pkg::ADDR_CONTROL, 8'h80);
        wr(sync_regs_pkg::ADDR_WINDOW, 8'h02);
        u_spi_host_model.pulse(9'h00a, 9'h005);
        chk_cnt(0);
        wr(sync_regs_pkg::ADDR_MODE, 8'h02);
        u_spi_host_model.pulse(9'h00a, 9'h005);
        rd(sync_regs_pkg::ADDR_ERR_LOW, 8'h05);
        rd(sync_regs_pkg::ADDR_ERR_HIGH, 8'h40);
        u_spi_host_model.pulse(9'h005, 9'h00a);
        rd(sync_regs_pkg::ADDR_ERR_LOW, 8'hfb);
        rd(sync_regs_pkg::ADDR_ERR_HIGH, 8'h81);
        u_spi_host_model.pulse(9'h006, 9'h005);
        chk_cnt(2);
        wr(sync_regs_pkg::ADDR_ERR_LOW, 8'h00);
        rd(sync_regs_pkg::ADDR_ERR_LOW, 8'hfb);
        rd(sync_regs_pkg::ADDR_STATUS, 8'h03);
        wr(sync_regs_pkg::ADDR_CONTROL, 8'ha0);
        rd(sync_regs_pkg::ADDR_STATUS, 8'h00);
        rd(sync_regs_pkg::ADDR_ERR_HIGH, 8'h81);
        wr(sync_regs_pkg::ADDR_CONTROL, 8'h90);
        rd(sync_regs_pkg::ADDR_ERR_LOW, 8'h00);
        rd(sync_regs_pkg::ADDR_ERR_HIGH, 8'h00);
        wr(sync_regs_pkg::ADDR_CONTROL, 8'h00);
        u_spi_host_model.pulse(9'h00a, 9'h005);
        chk_cnt(2);
        wr(sync_regs_pkg::ADDR_CONTROL, 8'h80);
        wr(sync_regs_pkg::ADDR_WINDOW, 8'h07);
        u_spi_host_model.pulse(9'h007, 9'h000);
        chk_cnt(2);
        u_spi_host_model.pulse(9'h000, 9'h008);
        chk_cnt(3);
        rd(sync_regs_pkg::ADDR_ERR_HIGH, 8'h81);
        wr(sync_regs_pkg::ADDR_WINDOW, 8'h00);
        u_spi_host_model.pulse(9'h001, 9'h000);
        chk_cnt(4);
        wr(sync_regs_pkg::ADDR_MODE, 8'h01);
        u_spi_host_model.pulse(9'h005, 9'h000);
        chk_cnt(4);
        wr(sync_regs_pkg::ADDR_CONTROL, 8'hc0);
        rd(sync_regs_pkg::ADDR_CONTROL, 8'h80);
        u_spi_host_model.pulse(9'h005, 9'h000);
        u_spi_host_model.pulse(9'h005, 9'h000);
        chk_cnt(5);
        wr(sync_regs_pkg::ADDR_CONTROL, 8'ha0);
        wr(sync_regs_pkg::ADDR_MODE, 8'h08);
        u_spi_host_model.pulse(9'h005, 9'h000);
        chk_cnt(5);
        rd(sync_regs_pkg::ADDR_STATUS, 8'h01);
        for (int m = 9; m < 11; m++)
        begin
            wr(sync_regs_pkg::ADDR_MODE, 8'(m));
            wr(sync_regs_pkg::ADDR_CONTROL, 8'he0);
            u_spi_host_model.pulse(9'h005, 9'h000);
            u_spi_host_model.pulse(9'h005, 9'h000);
            chk_cnt(m - 3);
            rd(sync_regs_pkg::ADDR_STATUS, 8'h03);
        end
        print_verdict();
    end
endmodule

bind sync_status_control sync_status_control_properties u_sync_status_control_properties (.sys_clk(sys_clk),
    .resetn(resetn), .spi_csn(spi_csn), .spi_sdio_oe(spi_sdio_oe), .sysref_strobe(sysref_strobe),
    .sampled_phase(sampled_phase), .target_phase(target_phase), .clock_adjust(clock_adjust),
    .adjust_error(adjust_error), .reference_rotation_flag(reference_rotation_flag),
    .window_trip_flag(window_trip_flag));
